// ---- hw/pulse_ctrl_defines.svh ----
// Offsets, field positions, reset values and timing defaults of the pulse generation control block.
// Included by the package and the design; holds definitions only.
`ifndef PULSE_CTRL_DEFINES_SVH
`define PULSE_CTRL_DEFINES_SVH

`define ADDR_W 12
`define OFS_CTRL 12'h100
`define OFS_STATUS 12'h104
`define OFS_WIDTH 12'h108
`define OFS_PERIOD 12'h10C
`define OFS_IRQ_STATUS 12'h110
`define OFS_IRQ_MASK 12'h114
`define OFS_DELAY_B 12'h118

`define BIT_SYNC_EN 0
`define BIT_A_EN 1
`define BIT_B_EN 2
`define BIT_A_ACK 4
`define BIT_A_CYC 5
`define BIT_B_ACK 6
`define BIT_B_CYC 7
`define BIT_B_IND 8
`define CTRL_WMASK 32'h0000_01F7
`define CTRL_RESET 32'h0000_0000

`define IRQ_A_START 0
`define IRQ_B_START 1
`define IRQ_A_END 2
`define IRQ_B_END 3
`define IRQ_W 4

`define WIDTH_RESET 32'h0000_0010
`define PERIOD_RESET 32'h0000_0100
`define DELAY_RESET 32'h0000_0000

`endif

// ---- hw/pulse_ctrl_pkg.sv ----
// Types shared by the pulse generation control block.
// Assumes pulse_ctrl_defines.svh sits on the include path.
`include "pulse_ctrl_defines.svh"

package pulse_ctrl_pkg;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [3:0] {
    CH_IDLE = 4'h1,
    CH_WAIT = 4'h2,
    CH_HIGH = 4'h4,
    CH_HOLD = 4'h8
  } ch_state_t;

endpackage : pulse_ctrl_pkg

// ---- hw/pulse_ctrl.sv ----
// Two synchronisation pulse outputs with single-shot or cyclic modes and hold-until-acknowledge.
// Assumes a register master on SYS_CLK with one-cycle strobes and read data one cycle later.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`include "pulse_ctrl_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Bit 8 set: output b runs on its own timing; clear: b follows a.
// - Bit 7 picks single pulse or cyclic repetition for output b.
// - Bit 5 picks single pulse or cyclic repetition for output a.
// - Acknowledge bit clear (6 b, 4 a): output drops when width has elapsed.
// - Acknowledge bit set: output held until software reads status flag, which clears.
// - Writable control bits reset to 0; bits 31..9 and 3 read zero, ignore writes.
module pulse_ctrl
  import pulse_ctrl_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [`ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic PULSE_OUT_A,
  output logic PULSE_OUT_B,
  output logic IRQ
);

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("CNT_W must be 2..32");
  end

  bus_req_t req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_q;
  logic [CNT_W-1:0] width_q, period_q, delay_b_q;
  logic [`IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic [1:0] flag_q;
  logic [31:0] rdata_q;

  wire sync_en = ctrl_q[`BIT_SYNC_EN];
  wire b_ind = ctrl_q[`BIT_B_IND];
  wire [1:0] ch_en = {ctrl_q[`BIT_B_EN], ctrl_q[`BIT_A_EN]} & {2{sync_en}};
  wire [1:0] ch_cyc = {ctrl_q[`BIT_B_CYC], ctrl_q[`BIT_A_CYC]};
  wire [1:0] ch_ack = {ctrl_q[`BIT_B_ACK], ctrl_q[`BIT_A_ACK]};
  wire status_rd = req.rd && req.addr == `OFS_STATUS;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ctrl_q <= `CTRL_RESET;
    end else if (req.wr && req.addr == `OFS_CTRL) begin
      ctrl_q <= req.wdata & `CTRL_WMASK;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      width_q <= CNT_W'(`WIDTH_RESET);
      period_q <= CNT_W'(`PERIOD_RESET);
      delay_b_q <= CNT_W'(`DELAY_RESET);
    end else if (req.wr) begin
      if (req.addr == `OFS_WIDTH) width_q <= req.wdata[CNT_W-1:0];
      if (req.addr == `OFS_PERIOD) period_q <= req.wdata[CNT_W-1:0];
      if (req.addr == `OFS_DELAY_B) delay_b_q <= req.wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      irq_mask_q <= '0;
    end else if (req.wr && req.addr == `OFS_IRQ_MASK) begin
      irq_mask_q <= req.wdata[`IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse channels: index 0 is output a, 1 is output b
  ch_state_t st_q [2];
  logic [CNT_W-1:0] cnt_q [2];
  logic [1:0] out_q, start_ev;
  logic [1:0] ch_go;
  // Pulse kept up past its width, waiting for the status read
  logic [1:0] held_high;

  // Dependent b starts with a; independent b starts after its own delay
  assign ch_go[0] = ch_en[0];
  assign ch_go[1] = ch_en[1] && (b_ind || st_q[0] != CH_IDLE || ch_en[0]);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [CNT_W-1:0] lead;
      logic width_done, period_done;
      assign lead = (g == 1 && b_ind) ? delay_b_q : '0;
      assign width_done = cnt_q[g] >= width_q - CNT_W'(1);
      assign period_done = cnt_q[g] >= period_q - CNT_W'(1);
      assign start_ev[g] = (st_q[g] == CH_WAIT) && cnt_q[g] >= lead;
      assign held_high[g] = out_q[g] && ch_ack[g] &&
        ((st_q[g] == CH_HIGH && width_done) || st_q[g] == CH_HOLD);

      always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
          st_q[g] <= CH_IDLE;
          cnt_q[g] <= '0;
          out_q[g] <= 1'b0;
        end else if (!ch_go[g]) begin
          st_q[g] <= CH_IDLE;
          cnt_q[g] <= '0;
          out_q[g] <= 1'b0;
        end else begin
          unique case (st_q[g])
            CH_IDLE: begin
              st_q[g] <= CH_WAIT;
              cnt_q[g] <= '0;
            end
            CH_WAIT: begin
              cnt_q[g] <= cnt_q[g] + CNT_W'(1);
              if (start_ev[g]) begin
                st_q[g] <= CH_HIGH;
                cnt_q[g] <= '0;
                out_q[g] <= 1'b1;
              end
            end
            CH_HIGH: begin
              if (!period_done) cnt_q[g] <= cnt_q[g] + CNT_W'(1);
              if (width_done && !ch_ack[g]) begin
                out_q[g] <= 1'b0;
                st_q[g] <= CH_HOLD;
              end else if (width_done && ch_ack[g] && status_rd) begin
                out_q[g] <= 1'b0;
                st_q[g] <= CH_HOLD;
              end
            end
            CH_HOLD: begin
              // Low phase runs out the period; a held pulse stays up until the status read
              if (!period_done) cnt_q[g] <= cnt_q[g] + CNT_W'(1);
              if (status_rd) out_q[g] <= 1'b0;
              if (period_done && (!out_q[g] || status_rd)) begin
                if (ch_cyc[g]) begin
                  st_q[g] <= CH_HIGH;
                  cnt_q[g] <= '0;
                  out_q[g] <= 1'b1;
                end
              end
            end
            default: begin
              st_q[g] <= CH_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // Status flag: set when a pulse starts, cleared by reading it; a new start wins over the read
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      flag_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (start_ev[i] || (st_q[i] == CH_HOLD && ch_cyc[i] && !out_q[i] && cnt_q[i] >= period_q - CNT_W'(1))) begin
          flag_q[i] <= 1'b1;
        end else if (status_rd) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  assign PULSE_OUT_A = out_q[0];
  assign PULSE_OUT_B = out_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [1:0] rise, fall;
  logic [1:0] out_d1_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) out_d1_q <= '0;
    else out_d1_q <= out_q;
  end
  assign rise = out_q & ~out_d1_q;
  assign fall = ~out_q & out_d1_q;

  wire [`IRQ_W-1:0] irq_set = {fall[1], fall[0], rise[1], rise[0]};
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      irq_stat_q <= '0;
    end else begin
      logic [`IRQ_W-1:0] clr;
      clr = (req.wr && req.addr == `OFS_IRQ_STATUS) ? req.wdata[`IRQ_W-1:0] : '0;
      // Set wins so an event in the clearing cycle is kept
      irq_stat_q <= (irq_stat_q & ~clr) | irq_set;
    end
  end
  assign IRQ = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rdata_q <= '0;
    end else if (req.rd) begin
      unique case (req.addr)
        `OFS_CTRL: rdata_q <= ctrl_q & `CTRL_WMASK;
        `OFS_STATUS: rdata_q <= {28'h0, held_high, flag_q};
        `OFS_WIDTH: rdata_q <= 32'(width_q);
        `OFS_PERIOD: rdata_q <= 32'(period_q);
        `OFS_IRQ_STATUS: rdata_q <= 32'(irq_stat_q);
        `OFS_IRQ_MASK: rdata_q <= 32'(irq_mask_q);
        `OFS_DELAY_B: rdata_q <= 32'(delay_b_q);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    1'b1 |-> (ctrl_q & ~`CTRL_WMASK) == 32'h0) else $error("reserved control bits set");
  a_gate_a_off: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !(sync_en && ctrl_q[`BIT_A_EN]) |=> !PULSE_OUT_A) else $error("a pulses while disabled");
  a_gate_b_off: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !(sync_en && ctrl_q[`BIT_B_EN]) |=> !PULSE_OUT_B) else $error("b pulses while disabled");
  a_width_drop_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (st_q[0] == CH_HIGH && cnt_q[0] >= width_q - CNT_W'(1) && !ch_ack[0] && ch_go[0]) |=> !PULSE_OUT_A)
    else $error("a not dropped at width");
  a_width_drop_b: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (st_q[1] == CH_HIGH && cnt_q[1] >= width_q - CNT_W'(1) && !ch_ack[1] && ch_go[1]) |=> !PULSE_OUT_B)
    else $error("b not dropped at width");
  a_hold_until_read: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (held_high[0] && !status_rd && ch_go[0]) |=> PULSE_OUT_A) else $error("held a released early");
  a_read_clears: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (status_rd && held_high[0]) |=> !PULSE_OUT_A) else $error("status read did not release a");
  a_single_shot_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (st_q[0] == CH_HOLD && !ch_cyc[0] && !out_q[0] && ch_go[0]) |=> !PULSE_OUT_A)
    else $error("single shot a repeated");
  a_single_shot_b: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (st_q[1] == CH_HOLD && !ch_cyc[1] && !out_q[1] && ch_go[1]) |=> !PULSE_OUT_B)
    else $error("single shot b repeated");
  a_dependent_b: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    (!b_ind && st_q[1] == CH_IDLE && !ch_go[1]) |=> !PULSE_OUT_B) else $error("idle b pulsed");

endmodule : pulse_ctrl

// ---- test/tb_top.sv ----
// Self-checking bench for the pulse generation control block.
// Drives the register port directly; assumes pulse_ctrl_defines.svh on the include path.
`timescale 1ns/1ns
`include "pulse_ctrl_defines.svh"

module tb_top import pulse_ctrl_pkg::*;;
  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [`ADDR_W-1:0] ADDR = '0;
  logic [31:0] WDATA = 32'h0000_0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic PULSE_OUT_A;
  logic PULSE_OUT_B;
  logic IRQ;
  int err_count = 0;
  int samples_checked = 0;
  logic [31:0] rd_val;

  pulse_ctrl DUT (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PULSE_OUT_A(PULSE_OUT_A), .PULSE_OUT_B(PULSE_OUT_B), .IRQ(IRQ));

  always #4 SYS_CLK = ~SYS_CLK;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic step;
    @(posedge SYS_CLK);
    #1;
  endtask : step

  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken right there
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd

  function automatic logic pin(input bit b);
    return b ? PULSE_OUT_B : PULSE_OUT_A;
  endfunction : pin

  // Latency to the first edge is left loose; run lengths carry the timing
  task automatic measure(input bit b, output int hi, output int lo);
    int i;
    hi = 0;
    lo = 0;
    step();
    for (i = 0; i < 12 && pin(b) !== 1'b1; i++) step();
    while (pin(b) === 1'b1 && hi < 20) begin
      step();
      hi++;
    end
    while (pin(b) !== 1'b1 && lo < 20) begin
      step();
      lo++;
    end
  endtask : measure

  // Clearing control first re-arms a single shot left from the previous case
  task automatic run(input string name, input bit b, input logic [31:0] ctrl, input int ehi, input int elo);
    int hi;
    int lo;
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_CTRL, ctrl);
    measure(b, hi, lo);
    chk({name, "_high"}, ehi, hi);
    chk({name, "_low"}, elo, lo);
  endtask : run

  // A first status read drops flags left over from earlier cases
  task automatic ack_release(input string name, input bit b, input logic [31:0] ctrl);
    rd(`OFS_STATUS, rd_val);
    run(name, b, ctrl, 20, 0);
    rd(`OFS_STATUS, rd_val);
    chk({name, "_status"}, b ? 32'h0000_000A : 32'h0000_0005, rd_val);
    step();
    step();
    chk({name, "_released"}, 32'h0000_0000, {31'h0, pin(b)});
    rd(`OFS_STATUS, rd_val);
    chk({name, "_flag_cleared"}, 32'h0000_0000, rd_val);
  endtask : ack_release

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rd(`OFS_CTRL, rd_val);
    chk("ctrl_reset", 32'h0000_0000, rd_val);
    wr(`OFS_CTRL, 32'hFFFF_FFFF);
    rd(`OFS_CTRL, rd_val);
    chk("ctrl_reserved", 32'h0000_01F7, rd_val);
    rd(12'h1FC, rd_val);
    chk("unmapped", 32'h0000_0000, rd_val);
    wr(`OFS_WIDTH, 32'h0000_0002);
    wr(`OFS_PERIOD, 32'h0000_0004);
    run("a_cyclic", 1'b0, 32'h0000_0023, 2, 2);
    run("a_single", 1'b0, 32'h0000_0003, 2, 20);
    run("b_dependent", 1'b1, 32'h0000_00A7, 2, 2);
    run("b_ind_single", 1'b1, 32'h0000_0127, 2, 20);
    run("b_ind_cyclic", 1'b1, 32'h0000_01A7, 2, 2);
    run("no_global", 1'b0, 32'h0000_0026, 0, 20);
    run("no_a_enable", 1'b0, 32'h0000_0021, 0, 20);
    run("no_b_enable", 1'b1, 32'h0000_0183, 0, 20);
    ack_release("a_ack", 1'b0, 32'h0000_0013);
    ack_release("b_ack", 1'b1, 32'h0000_0145);
    wr(`OFS_CTRL, 32'h0000_0000);
    wr(`OFS_IRQ_STATUS, 32'h0000_000F);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    step();
    chk("irq_idle", 32'h0000_0000, {31'h0, IRQ});
    run("irq_pulse", 1'b0, 32'h0000_0003, 2, 20);
    chk("irq_raised", 32'h0000_0001, {31'h0, IRQ});
    wr(`OFS_IRQ_MASK, 32'h0000_0000);
    step();
    chk("irq_masked", 32'h0000_0000, {31'h0, IRQ});
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    wr(`OFS_IRQ_STATUS, 32'h0000_0001);
    step();
    chk("irq_cleared", 32'h0000_0000, {31'h0, IRQ});
    give_verdict();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    err_count++;
    give_verdict();
  end
endmodule : tb_top
